// ---- design/elm_pkg.sv ----
// Constants, encodings and state carrier for the event-log mission control block
package elm_pkg;
  // Register addresses
  localparam logic [7:0] ELM_ADDR_CTRL = 8'h0e;
  localparam logic [7:0] ELM_ADDR_STATUS = 8'h0f;
  // Control register bit positions
  localparam int ELM_C_ARM = 7;
  localparam int ELM_C_CLRA = 6;
  localparam int ELM_C_DIS_HI = 5;
  localparam int ELM_C_DIS_LO = 4;
  localparam int ELM_C_WRAP = 3;
  localparam int ELM_C_EDGE_HI = 2;
  localparam int ELM_C_EDGE_LO = 1;
  localparam int ELM_C_OSC = 0;
  // Status register bit positions
  localparam int ELM_S_MEMCLR = 6;
  localparam int ELM_S_ACTIVE = 5;
  localparam int ELM_S_CM = 4;
  localparam int ELM_S_LOW_BATTERY_FLAG = 3;
  localparam int ELM_S_OVF = 2;
  localparam int ELM_S_ALARM = 0;
  // Field codes
  localparam logic [1:0] ELM_DIS_ALARM = 2'h0;
  localparam logic [1:0] ELM_DIS_SEC = 2'h1;
  localparam logic [1:0] ELM_DIS_MIN = 2'h2;
  localparam logic [1:0] ELM_DIS_HOUR = 2'h3;
  localparam logic [1:0] ELM_EDGE_NONE = 2'h0;
  localparam logic [1:0] ELM_EDGE_FALL = 2'h1;
  localparam logic [1:0] ELM_EDGE_RISE = 2'h2;
  localparam logic [1:0] ELM_EDGE_BOTH = 2'h3;
  // Log geometry
  localparam int ELM_LOG_BYTES = 2048;
  localparam int ELM_PTR_W = 11;
  localparam logic [ELM_PTR_W-1:0] ELM_PTR_ZERO = 11'h000;
  localparam logic [ELM_PTR_W-1:0] ELM_PTR_STEP = 11'h002;
  localparam logic [ELM_PTR_W-1:0] ELM_PTR_LAST = 11'h7fe;
  localparam logic [15:0] ELM_ETC_MAX = 16'hffff;
  localparam logic [15:0] ELM_ETC_ZERO = 16'h0000;
  localparam logic [15:0] ELM_ETC_ONE = 16'h0001;
  localparam logic [23:0] ELM_EVCNT_ONE = 24'h000001;
  localparam logic [15:0] ELM_CNT_ONE = 16'h0001;
  localparam logic [7:0] ELM_CTRL_RESET = 8'h00;
  // Clear timing
  localparam int ELM_CLK_FREQ_HZ = 25_000_000;
  localparam int ELM_CLEAR_TIME_US = 500;
  localparam int ELM_CLEAR_CYCLES = ELM_CLEAR_TIME_US * (ELM_CLK_FREQ_HZ / 1_000_000);
  // Operating modes
  typedef enum logic [2:0] {
    ELM_MD_IDLE = 3'b001,
    ELM_MD_ACTIVE = 3'b010,
    ELM_MD_CLEAR = 3'b100
  } elm_mode_t;
  // Log memory write port
  typedef struct packed {
    logic wr;
    logic [ELM_PTR_W-1:0] addr;
    logic [15:0] data;
  } elm_log_wr_t;
  // Whole block state
  typedef struct packed {
    elm_mode_t mode;
    logic [7:0] ctrl;
    logic mem_cleared;
    logic overflow;
    logic alarm;
    logic [2:0] sync;
    logic ticked;
    logic [15:0] elapsed_time_counter;
    logic [ELM_PTR_W-1:0] ptr;
    logic full;
    logic [23:0] evcnt;
    elm_log_wr_t log;
    logic stamp_cap;
    logic wrap_wr;
    logic [15:0] wrap_val;
    logic [15:0] clr_cnt;
    logic [7:0] rdata;
  } elm_state_t;
  localparam elm_state_t ELM_STATE_RESET = '{
    mode: ELM_MD_IDLE, ctrl: ELM_CTRL_RESET, mem_cleared: 1'b0, overflow: 1'b0,
    alarm: 1'b0, sync: 3'h0, ticked: 1'b0, elapsed_time_counter: 16'h0000, ptr: 11'h000, full: 1'b0,
    evcnt: 24'h000000, log: '{wr: 1'b0, addr: 11'h000, data: 16'h0000},
    stamp_cap: 1'b0, wrap_wr: 1'b0, wrap_val: 16'h0000, clr_cnt: 16'h0000,
    rdata: 8'h00
  };
endpackage : elm_pkg

// ---- design/elm_mission_ctrl.sv ----
// Mission control, event logging and status logic of the event recorder
`timescale 1ns/1ps
// Summary of operation
// - Interval field picks alarm, second, minute, hour
// - Event before any tick logs zero, restarts
// - Wrap enable wraps log after 2048 bytes
// - Event after 1024th stamps start and wrap
// - After wrap, logging restarts at address zero
// - Wrap stamp loaded zero at mission start
// - Full log without wrap stops writes, counts
// - Edge field: fall, rise, both, none illegal
// - No start with bad edge, interval, oscillator
// - Oscillator disable halts timekeeping, keeps memory
// - Memory clear needs oscillator enable bit set
// - Main supply above backup forces oscillator on
// - Memory-cleared flag set by clear, dropped at start
// - Armed mission goes active on first edge
// - Writing active one starts mission, sets arm
// - Active one ignored unless memory cleared
// - Clear or any host write other than to status ends mission
// - Writing active zero stops mission, clears arm
// - Armed clear trigger zeroes log, counter, stamp
// - Clear trigger must directly follow arm write
// - Overflow flag on event into full log
// - Tick with counter at FFFE logs FFFF, restarts counter at zero
// - Any mission stop clears the arm bit
module elm_mission_ctrl
  import elm_pkg::*;
#(
  parameter int CLEAR_CYCLES = ELM_CLEAR_CYCLES
) (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESETN_I,
  // Register access from the serial bus slave
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  // Event pin and calendar ticks
  input wire logic EVENT_PIN_I,
  input wire logic SEC_TICK_I,
  input wire logic MIN_TICK_I,
  input wire logic HOUR_TICK_I,
  // Supply, battery and alarm
  input wire logic VCC_ABOVE_BAT_I,
  input wire logic LOW_BAT_I,
  input wire logic ALARM_MATCH_I,
  input wire logic ALARM_ACCESS_I,
  output logic OSC_RUN_O,
  output logic ALARM_INT_N_O,
  // Event-log memory and stamps
  output logic LOG_WR_O,
  output logic [ELM_PTR_W-1:0] LOG_ADDR_O,
  output logic [15:0] LOG_DATA_O,
  output logic STAMP_CAPTURE_O,
  output logic WRAP_STAMP_WR_O,
  output logic [15:0] WRAP_STAMP_O,
  output logic MEM_CLEAR_O,
  // Mission state
  output logic MISSION_ACTIVE_O,
  output logic [23:0] EVENT_COUNT_O,
  output logic [ELM_PTR_W-1:0] ADDR_PTR_O
);

  if (CLEAR_CYCLES < 1 || CLEAR_CYCLES > 65535) begin : g_chk
    $error("CLEAR_CYCLES must lie in 1..65535");
  end

  localparam logic [15:0] CLEAR_LAST = 16'(CLEAR_CYCLES - 1);

  elm_state_t s;
  elm_state_t next_s;

  logic [1:0] dis_sel;
  logic [1:0] edge_sel;
  logic osc_run;
  logic rise;
  logic fall;
  logic event_hit;
  logic tick;
  logic start_ok;

  assign dis_sel = {s.ctrl[ELM_C_DIS_HI], s.ctrl[ELM_C_DIS_LO]};
  assign edge_sel = {s.ctrl[ELM_C_EDGE_HI], s.ctrl[ELM_C_EDGE_LO]};
  assign osc_run = s.ctrl[ELM_C_OSC] | VCC_ABOVE_BAT_I;
  assign rise = s.sync[1] & ~s.sync[2];
  assign fall = ~s.sync[1] & s.sync[2];
  assign start_ok = (edge_sel != ELM_EDGE_NONE) && (dis_sel != ELM_DIS_ALARM)
                    && s.ctrl[ELM_C_OSC];

  always_comb begin
    unique case (edge_sel)
      ELM_EDGE_FALL: event_hit = fall;
      ELM_EDGE_RISE: event_hit = rise;
      ELM_EDGE_BOTH: event_hit = rise | fall;
      ELM_EDGE_NONE: event_hit = 1'b0;
    endcase
  end

  always_comb begin
    unique case (dis_sel)
      ELM_DIS_SEC: tick = SEC_TICK_I & osc_run;
      ELM_DIS_MIN: tick = MIN_TICK_I & osc_run;
      ELM_DIS_HOUR: tick = HOUR_TICK_I & osc_run;
      ELM_DIS_ALARM: tick = 1'b0;
    endcase
  end

  always_comb begin
    logic stop;
    logic start;
    logic do_log;
    logic [15:0] log_val;
    stop = 1'b0;
    start = 1'b0;
    do_log = 1'b0;
    log_val = ELM_ETC_ZERO;
    next_s = s;
    next_s.log.wr = 1'b0;
    next_s.stamp_cap = 1'b0;
    next_s.wrap_wr = 1'b0;
    next_s.sync = {s.sync[1:0], EVENT_PIN_I};
    next_s.alarm = ALARM_MATCH_I | (s.alarm & ~ALARM_ACCESS_I);
    unique case (REG_ADDR_I)
      ELM_ADDR_CTRL: next_s.rdata = s.ctrl;
      ELM_ADDR_STATUS: next_s.rdata = {1'b0, s.mem_cleared, s.mode == ELM_MD_ACTIVE,
                                       s.mode == ELM_MD_CLEAR, LOW_BAT_I, s.overflow,
                                       1'b0, s.alarm};
      default: next_s.rdata = 8'h00;
    endcase

    if (REG_WR_I && s.mode != ELM_MD_CLEAR) begin
      if (REG_ADDR_I == ELM_ADDR_STATUS) begin
        next_s.ctrl[ELM_C_CLRA] = 1'b0;
        if (REG_WDATA_I[ELM_S_CM] && s.ctrl[ELM_C_CLRA] && s.ctrl[ELM_C_OSC]) begin
          stop = 1'b1;
          next_s.clr_cnt = 16'h0000;
        end else if (s.mode == ELM_MD_ACTIVE && !REG_WDATA_I[ELM_S_ACTIVE]) begin
          stop = 1'b1;
        end else if (s.mode == ELM_MD_IDLE && REG_WDATA_I[ELM_S_ACTIVE]
                     && s.mem_cleared && start_ok) begin
          start = 1'b1;
        end
      end else begin
        if (REG_ADDR_I == ELM_ADDR_CTRL) begin
          next_s.ctrl = REG_WDATA_I;
          next_s.ctrl[ELM_C_ARM] = REG_WDATA_I[ELM_C_ARM] & s.mem_cleared
                                   & (s.mode != ELM_MD_ACTIVE);
        end else begin
          next_s.ctrl[ELM_C_CLRA] = 1'b0;
        end
        stop = (s.mode == ELM_MD_ACTIVE);
      end
    end else begin
      unique case (s.mode)
        ELM_MD_IDLE: begin
          if (event_hit && s.ctrl[ELM_C_ARM] && start_ok) begin
            start = 1'b1;
          end
        end
        ELM_MD_ACTIVE: begin
          if (event_hit) begin
            next_s.evcnt = s.evcnt + ELM_EVCNT_ONE;
            next_s.elapsed_time_counter = ELM_ETC_ZERO;
            next_s.ticked = 1'b0;
            if (s.full) begin
              next_s.overflow = 1'b1;
              if (s.ctrl[ELM_C_WRAP]) begin
                next_s.stamp_cap = 1'b1;
                next_s.wrap_wr = 1'b1;
                next_s.wrap_val = s.elapsed_time_counter;
                next_s.full = 1'b0;
                next_s.ptr = ELM_PTR_ZERO;
              end
            end else begin
              do_log = 1'b1;
              log_val = s.ticked ? s.elapsed_time_counter : ELM_ETC_ZERO;
            end
          end else if (tick) begin
            next_s.ticked = 1'b1;
            if (s.elapsed_time_counter == ELM_ETC_MAX - ELM_ETC_ONE) begin
              next_s.elapsed_time_counter = ELM_ETC_ZERO;
              do_log = ~s.full;
              log_val = ELM_ETC_MAX;
            end else begin
              next_s.elapsed_time_counter = s.elapsed_time_counter + ELM_ETC_ONE;
            end
          end
        end
        ELM_MD_CLEAR: begin
          next_s.clr_cnt = s.clr_cnt + ELM_CNT_ONE;
          if (s.clr_cnt == CLEAR_LAST) begin
            next_s.mode = ELM_MD_IDLE;
            next_s.mem_cleared = 1'b1;
            next_s.evcnt = 24'h000000;
            next_s.ptr = ELM_PTR_ZERO;
            next_s.full = 1'b0;
            next_s.overflow = 1'b0;
            next_s.elapsed_time_counter = ELM_ETC_ZERO;
            next_s.ctrl[ELM_C_CLRA] = 1'b0;
          end
        end
      endcase
    end

    if (do_log) begin
      next_s.log.wr = 1'b1;
      next_s.log.addr = s.ptr;
      next_s.log.data = log_val;
      next_s.ptr = s.ptr + ELM_PTR_STEP;
      if (s.ptr == ELM_PTR_LAST) begin
        next_s.full = 1'b1;
        next_s.ptr = ELM_PTR_ZERO;
      end
    end

    if (stop) begin
      next_s.mode = ELM_MD_IDLE;
      next_s.ctrl[ELM_C_ARM] = 1'b0;
    end
    if (stop && REG_ADDR_I == ELM_ADDR_STATUS && REG_WDATA_I[ELM_S_CM]
        && s.ctrl[ELM_C_CLRA] && s.ctrl[ELM_C_OSC]) begin
      next_s.mode = ELM_MD_CLEAR;
    end
    if (start) begin
      next_s.mode = ELM_MD_ACTIVE;
      next_s.ctrl[ELM_C_ARM] = 1'b1;
      next_s.mem_cleared = 1'b0;
      next_s.stamp_cap = 1'b1;
      next_s.wrap_wr = 1'b1;
      next_s.wrap_val = ELM_ETC_ZERO;
      next_s.evcnt = s.evcnt + ELM_EVCNT_ONE;
      next_s.elapsed_time_counter = ELM_ETC_ZERO;
      next_s.ticked = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      s <= ELM_STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign REG_RDATA_O = s.rdata;
  assign OSC_RUN_O = osc_run;
  assign ALARM_INT_N_O = ~(s.alarm && dis_sel == ELM_DIS_ALARM);
  assign LOG_WR_O = s.log.wr;
  assign LOG_ADDR_O = s.log.addr;
  assign LOG_DATA_O = s.log.data;
  assign STAMP_CAPTURE_O = s.stamp_cap;
  assign WRAP_STAMP_WR_O = s.wrap_wr;
  assign WRAP_STAMP_O = s.wrap_val;
  assign MEM_CLEAR_O = (s.mode == ELM_MD_CLEAR);
  assign MISSION_ACTIVE_O = (s.mode == ELM_MD_ACTIVE);
  assign EVENT_COUNT_O = s.evcnt;
  assign ADDR_PTR_O = s.ptr;

endmodule : elm_mission_ctrl

// ---- testbench/elm_mission_ctrl_assertions.sv ----
// Port-level checks of the mission control block
`timescale 1ns/1ps
module elm_mission_ctrl_assertions
  import elm_pkg::*;
#(
  parameter int CLEAR_CYCLES = 4
) (
  // Clock, reset and register strobes
  input wire logic SYS_CLK_I,
  input wire logic RESETN_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  // Supply, alarm and mission outputs
  input wire logic VCC_ABOVE_BAT_I,
  input wire logic OSC_RUN_O,
  input wire logic ALARM_INT_N_O,
  input wire logic MEM_CLEAR_O,
  input wire logic MISSION_ACTIVE_O,
  input wire logic STAMP_CAPTURE_O,
  input wire logic WRAP_STAMP_WR_O,
  input wire logic [15:0] WRAP_STAMP_O,
  input wire logic [23:0] EVENT_COUNT_O
);
  logic [15:0] clr_n;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);
  // Length of the running clear
  always_ff @(posedge SYS_CLK_I) begin
    clr_n <= (MEM_CLEAR_O && RESETN_I) ? clr_n + 16'h1 : 16'h0;
  end
  a_osc_forced_on: assert property (VCC_ABOVE_BAT_I |-> OSC_RUN_O)
    else $error("oscillator not forced on");
  a_clear_after_trigger: assert property ($rose(MEM_CLEAR_O) |->
    $past(REG_WR_I && REG_ADDR_I == ELM_ADDR_STATUS && REG_WDATA_I[ELM_S_CM]))
    else $error("clear without trigger write");
  a_clear_needs_osc: assert property ($rose(MEM_CLEAR_O) |-> $past(OSC_RUN_O))
    else $error("clear with oscillator stopped");
  a_clear_length: assert property ($fell(MEM_CLEAR_O) |->
    clr_n == CLEAR_CYCLES && EVENT_COUNT_O == 24'h0)
    else $error("clear length or counter wrong");
  a_write_stops: assert property (MISSION_ACTIVE_O && REG_WR_I &&
    REG_ADDR_I != ELM_ADDR_STATUS |=> !MISSION_ACTIVE_O)
    else $error("write did not stop mission");
  a_zero_stops: assert property (MISSION_ACTIVE_O && REG_WR_I &&
    REG_ADDR_I == ELM_ADDR_STATUS && !REG_WDATA_I[ELM_S_ACTIVE] |=> !MISSION_ACTIVE_O)
    else $error("status zero did not stop mission");
  a_start_stamps: assert property ($rose(MISSION_ACTIVE_O) |->
    STAMP_CAPTURE_O && WRAP_STAMP_WR_O && WRAP_STAMP_O == 16'h0)
    else $error("start stamps missing");
  a_start_count: assert property ($rose(MISSION_ACTIVE_O) |-> EVENT_COUNT_O == 24'h1)
    else $error("start count wrong");
  a_alarm_route: assert property (!ALARM_INT_N_O |-> !MISSION_ACTIVE_O)
    else $error("alarm output during mission");
  a_count_steps: assert property (MISSION_ACTIVE_O && $past(MISSION_ACTIVE_O) |->
    EVENT_COUNT_O - $past(EVENT_COUNT_O) <= 24'h1)
    else $error("event count jumped");
endmodule : elm_mission_ctrl_assertions

bind elm_mission_ctrl elm_mission_ctrl_assertions #(.CLEAR_CYCLES(CLEAR_CYCLES)) u_assert (
  .SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .REG_WR_I(REG_WR_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .VCC_ABOVE_BAT_I(VCC_ABOVE_BAT_I), .OSC_RUN_O(OSC_RUN_O),
  .ALARM_INT_N_O(ALARM_INT_N_O), .MEM_CLEAR_O(MEM_CLEAR_O), .MISSION_ACTIVE_O(MISSION_ACTIVE_O),
  .STAMP_CAPTURE_O(STAMP_CAPTURE_O), .WRAP_STAMP_WR_O(WRAP_STAMP_WR_O),
  .WRAP_STAMP_O(WRAP_STAMP_O), .EVENT_COUNT_O(EVENT_COUNT_O));

// ---- testbench/elm_host_model.sv ----
// Host master model issuing register writes and reads
`timescale 1ns/1ps
module elm_host_model
  import elm_pkg::*;
#(
  parameter int CLEAR_CYCLES = 4
) (
  // Clock and read data
  input wire logic SYS_CLK_I,
  input wire logic [7:0] REG_RDATA_I,
  // Register strobes
  output logic REG_WR_O,
  output logic [7:0] REG_ADDR_O,
  output logic [7:0] REG_WDATA_O
);
  initial begin
    REG_WR_O = 1'b0;
    REG_ADDR_O = 8'h00;
    REG_WDATA_O = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK_I);
    #1;
    REG_WR_O = 1'b1;
    REG_ADDR_O = a;
    REG_WDATA_O = d;
    @(posedge SYS_CLK_I);
    #1;
    REG_WR_O = 1'b0;
    REG_WDATA_O = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge SYS_CLK_I);
    #1;
    REG_ADDR_O = a;
    repeat (2) @(posedge SYS_CLK_I);
    d = REG_RDATA_I;
  endtask : rd
  // Arm then trigger as the very next write, then keep off the bus
  task automatic clear();
    wr(ELM_ADDR_CTRL, 8'h41);
    wr(ELM_ADDR_STATUS, 8'h10);
    repeat (CLEAR_CYCLES + 4) @(posedge SYS_CLK_I);
  endtask : clear
endmodule : elm_host_model

// ---- testbench/elm_mission_ctrl_test.sv ----
// Self-checking bench of the mission control block
`timescale 1ns/1ps
module elm_mission_ctrl_test
  import elm_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, ev_pin = 1'b0, sec = 1'b0, min_t = 1'b0, hour = 1'b0;
  logic vcc = 1'b0, low_battery_flag = 1'b0, alm = 1'b0, wr, osc_run, alm_n, log_wr, stamp, wrap_wr;
  logic memory_cleared_flag, active;
  logic [7:0] addr, wdata, rdata, lfsr = 8'h24, rd;
  logic [7:0] bad [3] = '{8'h11, 8'h12, 8'h03};
  logic [10:0] log_addr, ptr, last_addr;
  logic [15:0] log_data, wrap_val, last_data, w;
  logic [23:0] evcnt;
  logic [1:0] mode;
  int n_mismatch = 0, checked = 0, n_log = 0, n_wrap = 0;
  always #20 clk = ~clk;
  elm_host_model #(.CLEAR_CYCLES(4)) host (.SYS_CLK_I(clk), .REG_RDATA_I(rdata),
    .REG_WR_O(wr), .REG_ADDR_O(addr), .REG_WDATA_O(wdata));
  elm_mission_ctrl #(.CLEAR_CYCLES(4)) dut (.SYS_CLK_I(clk), .RESETN_I(rst_n), .REG_WR_I(wr),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .EVENT_PIN_I(ev_pin),
    .SEC_TICK_I(sec), .MIN_TICK_I(min_t), .HOUR_TICK_I(hour), .VCC_ABOVE_BAT_I(vcc),
    .LOW_BAT_I(low_battery_flag), .ALARM_MATCH_I(alm), .ALARM_ACCESS_I(1'b0), .OSC_RUN_O(osc_run),
    .ALARM_INT_N_O(alm_n), .LOG_WR_O(log_wr), .LOG_ADDR_O(log_addr), .LOG_DATA_O(log_data),
    .STAMP_CAPTURE_O(stamp), .WRAP_STAMP_WR_O(wrap_wr), .WRAP_STAMP_O(wrap_val),
    .MEM_CLEAR_O(memory_cleared_flag), .MISSION_ACTIVE_O(active), .EVENT_COUNT_O(evcnt), .ADDR_PTR_O(ptr));
  always @(posedge clk) begin
    if (log_wr === 1'b1) begin
      n_log <= n_log + 1;
      last_data <= log_data;
      last_addr <= log_addr;
    end
    if (wrap_wr === 1'b1) n_wrap <= n_wrap + 1;
  end
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic edge_to(input logic v);
    @(posedge clk);
    #1;
    ev_pin = v;
    repeat (6) @(posedge clk);
  endtask : edge_to
  task automatic event1();
    if (mode == ELM_EDGE_BOTH) edge_to(!ev_pin);
    else begin
      if (ev_pin == (mode == ELM_EDGE_RISE)) edge_to(!ev_pin);
      edge_to(mode == ELM_EDGE_RISE);
    end
  endtask : event1
  task automatic tick(input logic [2:0] t);
    @(posedge clk);
    #1;
    {hour, min_t, sec} = t;
    @(posedge clk);
    #1;
    {hour, min_t, sec} = 3'h0;
  endtask : tick
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    alm = 1'b1;
    low_battery_flag = lfsr[2];
    settle();
    chk(osc_run, 1'b0);
    chk(alm_n, 1'b0);
    vcc = 1'b1;
    alm = 1'b0;
    #1 chk(osc_run, 1'b1);
    host.wr(ELM_ADDR_STATUS, 8'h20);
    host.wr(ELM_ADDR_CTRL, 8'h40);
    host.wr(ELM_ADDR_STATUS, 8'h10);
    settle();
    chk({active, memory_cleared_flag}, 2'h0);
    host.wr(ELM_ADDR_CTRL, 8'h41);
    host.wr(ELM_ADDR_CTRL, 8'h01);
    host.wr(ELM_ADDR_STATUS, 8'h10);
    settle();
    chk(memory_cleared_flag, 1'b0);
    host.clear();
    host.rd(ELM_ADDR_STATUS, rd);
    chk(rd, {4'h4, low_battery_flag, 3'h1});
    foreach (bad[j]) begin
      host.wr(ELM_ADDR_CTRL, bad[j]);
      host.wr(ELM_ADDR_STATUS, 8'h20);
      settle();
      chk(active, 1'b0);
    end
    for (int i = 1; i < 4; i++) begin
      mode = i[1:0];
      host.clear();
      edge_to(mode == ELM_EDGE_RISE);
      host.wr(ELM_ADDR_CTRL, {2'h2, mode, 1'b0, mode, 1'b1});
      if (mode != ELM_EDGE_BOTH) edge_to(mode == ELM_EDGE_FALL);
      chk(active, 1'b0);
      event1();
      chk({active, evcnt}, {1'b1, 24'h1});
      tick(3'h1);
      tick(3'h2);
      tick(3'h4);
      event1();
      chk(last_data, 16'h1);
      event1();
      chk(last_data, 16'h0);
      host.wr(ELM_ADDR_STATUS, 8'h00);
      host.rd(ELM_ADDR_CTRL, rd);
      chk({active, rd[7]}, 2'h0);
    end
    mode = ELM_EDGE_BOTH;
    host.clear();
    host.wr(ELM_ADDR_CTRL, 8'h1f);
    n_log = 0;
    n_wrap = 0;
    host.wr(ELM_ADDR_STATUS, 8'h20);
    host.rd(ELM_ADDR_CTRL, rd);
    chk({active, rd}, {1'b1, 8'h9f});
    for (int k = 0; k < 1026; k++) begin
      lfsr = lfsr_next(lfsr);
      if (lfsr[0]) tick(3'h1);
      if (k == 1024) w = {15'h0, lfsr[0]};
      event1();
      if (k < 1024) chk(last_data, {15'h0, lfsr[0]});
    end
    chk(n_log, 24'd1025);
    chk({n_wrap[7:0], wrap_val}, {8'h2, w});
    chk({last_addr, evcnt}, {11'h0, 24'd1027});
    host.rd(ELM_ADDR_STATUS, rd);
    chk(rd[2], 1'b1);
    host.wr(ELM_ADDR_CTRL, 8'h1f);
    host.rd(ELM_ADDR_CTRL, rd);
    chk({active, rd}, {1'b0, 8'h1f});
    end_sim();
  end
endmodule : elm_mission_ctrl_test
